// ===== flash_space_pkg.sv
// Contract
// - Non-array spaces take a full 24-bit address though few locations are defined.
// - Main array splits into uniform erase sectors of 4 kbytes.
// - Array holds 512, 1024 or 2048 sectors, ending 1FFFFFh, 3FFFFFh, 7FFFFFh.
// - Low twelve address bits run within a sector; upper bits pick the sector.
// - Four security regions of 256 bytes each, outside the main array.
// - A region whose one-time lock bit is programmed stays protected forever.
// - Region 0 holds the parameter data, also readable by the parameter read.
// - Regions 1 to 3 erase, program and lock independently.
// - Region n sits at n times 1000h, offsets 00h to FFh.
// - Command 5Ah reads the separate parameter space, not the array.
// - Parameter space opens with a header giving revisions and table pointers.
// - Header points to a basic flash table and a sector map table.
// - Stored order is header, vendor table, basic table, sector map.
// - Parameter space is factory content; host writes to it are ignored.
// - Header at 0000h, first table 0080h, reserved 00C0h-00F7h, unique id 00F8h-00FFh.
// - Bytes 00h to 03h return 53h, 46h, 44h, 50h.
//
// Constants and carrier types for the flash address-space decoder.
// Assumes one 20 MHz system clock; the link pins are asynchronous to it.
package flash_space_pkg;

	// ==========================================================
	// Link framing
	localparam int CMD_BITS = 8;
	localparam int ADDR_BITS = 24;
	localparam int FRAME_BITS = CMD_BITS + ADDR_BITS;
	localparam logic [5:0] FRAME_LAST = 6'h1f;

	// ==========================================================
	// Command codes
	localparam logic [7:0] CMD_READ_PARAM = 8'h5a;
	localparam logic [7:0] CMD_READ_ARRAY = 8'h03;
	localparam logic [7:0] CMD_READ_SEC = 8'h48;
	localparam logic [7:0] CMD_PROG_SEC = 8'h42;
	localparam logic [7:0] CMD_ERASE_SEC = 8'h44;

	// ==========================================================
	// Address map
	localparam int SECTOR_SHIFT = 12;
	localparam int SECTOR_BYTES = 4096;
	localparam int SECTORS_MAX = 2048;
	localparam int REGION_COUNT = 4;
	localparam int REGION_BYTES = 256;
	localparam int REGION_LSB = 12;
	localparam logic [7:0] PARAM_HDR_BASE = 8'h00;
	localparam logic [7:0] PARAM_VENDOR_BASE = 8'h80;
	localparam logic [7:0] PARAM_BASIC_BASE = 8'h90;
	localparam logic [7:0] PARAM_SECMAP_BASE = 8'hb0;
	localparam logic [7:0] PARAM_UID_BASE = 8'hf8;
	localparam logic [7:0] PARAM_BLANK = 8'hff;
	localparam logic [7:0] SIG_S = 8'h53;
	localparam logic [7:0] SIG_F = 8'h46;
	localparam logic [7:0] SIG_D = 8'h44;
	localparam logic [7:0] SIG_P = 8'h50;
	localparam logic [7:0] HDR_MINOR = 8'h06;
	localparam logic [7:0] HDR_MAJOR = 8'h01;
	localparam logic [7:0] HDR_TABLES_M1 = 8'h02;
	localparam logic [7:0] ID_VENDOR_TBL = 8'h81;
	localparam logic [7:0] ID_BASIC_TBL = 8'h00;
	localparam logic [7:0] ID_SECMAP_TBL = 8'h81;
	localparam logic [7:0] TBL_VENDOR_DW = 8'h04;
	localparam logic [7:0] TBL_BASIC_DW = 8'h08;
	localparam logic [7:0] TBL_SECMAP_DW = 8'h04;

	// ==========================================================
	// Types
	typedef enum logic [1:0] {SPACE_NONE, SPACE_ARRAY, SPACE_SECURITY, SPACE_PARAM} space_type;

	typedef struct packed {
		space_type space;
		logic [ADDR_BITS-1:0] addr;
		logic [10:0] sector;
		logic [1:0] region;
		logic [7:0] offset;
		logic defined;
		logic write_req;
		logic reject;
		logic [7:0] rom_byte;
	} decode_type;

	typedef enum {ST_IDLE, ST_SHIFT, ST_DONE} frame_state_type;

endpackage

// ===== flash_space_map.sv
// Serial front end and address-space decoder for a serial flash device.
// Assumes link pins come straight from package balls, asynchronous to clk_in;
// lock bits come from the status word logic on clk_in.
`timescale 1ns/100ps

module flash_space_map #(
	parameter int SECTORS = 2048,
	parameter logic [63:0] UNIQUE_ID = 64'h0123_4567_89ab_cdef
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Serial link
	input wire logic sck_in,
	input wire logic cs_n_in,
	input wire logic si_in,
	// Status word lock bits, one per security region
	input wire logic [3:0] lock_bits_in,
	// Decoded access
	output logic decode_valid_out,
	output flash_space_pkg::decode_type decode_out
);

	// ==========================================================
	// Elaboration checks
	if (SECTORS != 512 && SECTORS != 1024 && SECTORS != 2048) begin : g_bad_sectors
		$error("SECTORS must be 512, 1024 or 2048");
	end

	localparam logic [24:0] ARRAY_END = 25'(SECTORS * flash_space_pkg::SECTOR_BYTES);

	// ==========================================================
	// Reset release
	logic rst_meta_q, rst_q;
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rst_meta_q <= 1'b0;
			rst_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_q <= rst_meta_q;
		end
	end

	// ==========================================================
	// Pin synchronisers
	logic [2:0] pin_meta_q, pin_sync_q;
	logic sck_prev_q;
	always_ff @(posedge clk_in or negedge rst_q) begin
		if (!rst_q) begin
			pin_meta_q <= 3'h2;
			pin_sync_q <= 3'h2;
			sck_prev_q <= 1'b0;
		end else begin
			pin_meta_q <= {si_in, cs_n_in, sck_in};
			pin_sync_q <= pin_meta_q;
			sck_prev_q <= pin_sync_q[0];
		end
	end

	logic sck_rise, cs_active, si_bit;
	assign sck_rise = pin_sync_q[0] && !sck_prev_q;
	assign cs_active = !pin_sync_q[1];
	assign si_bit = pin_sync_q[2];

	// ==========================================================
	// Frame capture: command byte then a full 24-bit address
	flash_space_pkg::frame_state_type state_q, state_d;
	logic [31:0] shift_q, shift_d;
	logic [5:0] count_q, count_d;
	logic frame_done;

	always_comb begin
		state_d = state_q;
		shift_d = shift_q;
		count_d = count_q;
		frame_done = 1'b0;
		case (state_q)
			flash_space_pkg::ST_IDLE: begin
				count_d = 6'h00;
				if (cs_active) begin
					state_d = flash_space_pkg::ST_SHIFT;
				end
			end
			flash_space_pkg::ST_SHIFT: begin
				if (!cs_active) begin
					state_d = flash_space_pkg::ST_IDLE;
				end else if (sck_rise) begin
					shift_d = {shift_q[30:0], si_bit};
					count_d = count_q + 6'h01;
					if (count_q == flash_space_pkg::FRAME_LAST) begin
						state_d = flash_space_pkg::ST_DONE;
						frame_done = 1'b1;
					end
				end
			end
			flash_space_pkg::ST_DONE: begin
				// Data phase belongs to the datapath; wait for deselect
				if (!cs_active) begin
					state_d = flash_space_pkg::ST_IDLE;
				end
			end
			default: begin
				state_d = flash_space_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_in or negedge rst_q) begin
		if (!rst_q) begin
			state_q <= flash_space_pkg::ST_IDLE;
			shift_q <= 32'h0000_0000;
			count_q <= 6'h00;
		end else begin
			state_q <= state_d;
			shift_q <= shift_d;
			count_q <= count_d;
		end
	end

	// ==========================================================
	// Parameter space contents
	function automatic logic [7:0] param_byte(input logic [7:0] off);
		logic [7:0] b;
		b = flash_space_pkg::PARAM_BLANK;
		case (off)
			8'h00: b = flash_space_pkg::SIG_S;
			8'h01: b = flash_space_pkg::SIG_F;
			8'h02: b = flash_space_pkg::SIG_D;
			8'h03: b = flash_space_pkg::SIG_P;
			8'h04: b = flash_space_pkg::HDR_MINOR;
			8'h05: b = flash_space_pkg::HDR_MAJOR;
			8'h06: b = flash_space_pkg::HDR_TABLES_M1;
			// Table headers at 08h, 10h, 18h
			8'h08: b = flash_space_pkg::ID_VENDOR_TBL;
			8'h0b: b = flash_space_pkg::TBL_VENDOR_DW;
			8'h0c: b = flash_space_pkg::PARAM_VENDOR_BASE;
			8'h10: b = flash_space_pkg::ID_BASIC_TBL;
			8'h13: b = flash_space_pkg::TBL_BASIC_DW;
			8'h14: b = flash_space_pkg::PARAM_BASIC_BASE;
			8'h18: b = flash_space_pkg::ID_SECMAP_TBL;
			8'h1b: b = flash_space_pkg::TBL_SECMAP_DW;
			8'h1c: b = flash_space_pkg::PARAM_SECMAP_BASE;
			8'h09, 8'h11, 8'h19: b = flash_space_pkg::HDR_MINOR;
			8'h0a, 8'h12, 8'h1a: b = flash_space_pkg::HDR_MAJOR;
			8'h0d, 8'h0e, 8'h15, 8'h16, 8'h1d, 8'h1e: b = 8'h00;
			default: begin
				if (off >= flash_space_pkg::PARAM_UID_BASE) begin
					b = UNIQUE_ID[{off[2:0], 3'h0} +: 8];
				end
			end
		endcase
		return b;
	endfunction

	// ==========================================================
	// Address-space decode
	flash_space_pkg::decode_type dec_d, dec_q;
	logic valid_d, valid_q;
	logic [7:0] cmd;
	logic [23:0] addr;
	assign cmd = shift_d[31:24];
	assign addr = shift_d[23:0];

	always_comb begin
		dec_d = dec_q;
		valid_d = frame_done;
		if (frame_done) begin
			dec_d = '0;
			dec_d.addr = addr;
			dec_d.offset = addr[7:0];
			dec_d.sector = addr[22:flash_space_pkg::SECTOR_SHIFT];
			dec_d.region = addr[flash_space_pkg::REGION_LSB +: 2];
			dec_d.rom_byte = flash_space_pkg::PARAM_BLANK;
			case (cmd)
				flash_space_pkg::CMD_READ_ARRAY: begin
					dec_d.space = flash_space_pkg::SPACE_ARRAY;
					dec_d.defined = {1'b0, addr} < ARRAY_END;
				end
				flash_space_pkg::CMD_READ_PARAM: begin
					dec_d.space = flash_space_pkg::SPACE_PARAM;
					dec_d.defined = addr[23:8] == 16'h0000;
					dec_d.rom_byte = param_byte(addr[7:0]);
				end
				flash_space_pkg::CMD_READ_SEC, flash_space_pkg::CMD_PROG_SEC,
				flash_space_pkg::CMD_ERASE_SEC: begin
					dec_d.space = flash_space_pkg::SPACE_SECURITY;
					dec_d.defined = addr[23:14] == 10'h000 && addr[11:8] == 4'h0;
					dec_d.write_req = cmd != flash_space_pkg::CMD_READ_SEC;
					if (dec_d.region == 2'h0) begin
						dec_d.rom_byte = param_byte(addr[7:0]);
					end
					// Region 0 is factory content; others follow own lock bit
					dec_d.reject = dec_d.write_req && (!dec_d.defined
						|| dec_d.region == 2'h0
						|| lock_bits_in[dec_d.region]);
				end
				default: begin
					dec_d.space = flash_space_pkg::SPACE_NONE;
				end
			endcase
		end
	end

	always_ff @(posedge clk_in or negedge rst_q) begin
		if (!rst_q) begin
			dec_q <= '0;
			valid_q <= 1'b0;
		end else begin
			dec_q <= dec_d;
			valid_q <= valid_d;
		end
	end

	assign decode_out = dec_q;
	assign decode_valid_out = valid_q;

	// ==========================================================
	// Checks
	// Edge count kept apart from the shifter, so a miscounting shifter shows
	logic [5:0] edges_q, edges_d;
	always_comb begin
		edges_d = edges_q;
		if (!cs_active) begin
			edges_d = '0;
		end else if (sck_rise && edges_q != '1) begin
			edges_d = edges_q + 6'h01;
		end
	end

	always_ff @(posedge clk_in or negedge rst_q) begin
		if (!rst_q) begin
			edges_q <= '0;
		end else begin
			edges_q <= edges_d;
		end
	end

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_q);

	frame_length_a: assert property (valid_q |-> edges_q == 6'(flash_space_pkg::FRAME_BITS))
		else $error("frame closed without 32 bits");
	valid_pulse_a: assert property (valid_q |=> !valid_q)
		else $error("decode valid longer than one cycle");
	sector_index_a: assert property (valid_q && dec_q.space == flash_space_pkg::SPACE_ARRAY
		|-> dec_q.sector == dec_q.addr[22:12])
		else $error("sector index not from upper address bits");
	array_end_a: assert property (valid_q && dec_q.space == flash_space_pkg::SPACE_ARRAY
		|-> dec_q.defined == (dec_q.addr[23:12] < 12'(SECTORS)))
		else $error("array bound decoded wrongly");
	signature_a: assert property (valid_q && dec_q.space == flash_space_pkg::SPACE_PARAM
		&& dec_q.addr == 24'h000000 |-> dec_q.rom_byte == 8'h53)
		else $error("signature byte wrong");
	locked_reject_a: assert property ($past(frame_done && lock_bits_in[addr[13:12]]) && valid_q
		&& dec_q.write_req |-> dec_q.reject)
		else $error("write to locked region accepted");
	param_write_a: assert property (valid_q && dec_q.write_req && dec_q.region == 2'h0
		|-> dec_q.reject)
		else $error("write to parameter region accepted");
	read_norej_a: assert property (valid_q && !dec_q.write_req |-> !dec_q.reject)
		else $error("read raised a reject");
	region_base_a: assert property (valid_q && dec_q.space == flash_space_pkg::SPACE_SECURITY
		&& dec_q.defined |-> dec_q.addr == {10'h000, dec_q.region, 4'h0, dec_q.offset})
		else $error("region base decode wrong");
	alias_a: assert property (valid_q && dec_q.space == flash_space_pkg::SPACE_SECURITY
		&& dec_q.region == 2'h0 |-> dec_q.rom_byte == param_byte(dec_q.offset))
		else $error("region 0 differs from parameter space");

endmodule

// ===== spi_host_model.sv
// Host-side model of the serial link: sends command frames to the decoder.
// Assumes the bench calls send() from one process; link timing is its own.
`timescale 1ns/100ps

module spi_host_model (
	// Bench clock
	input wire logic clk_in,
	// Serial link
	output logic sck_out,
	output logic cs_n_out,
	output logic si_out
);
	initial begin
		sck_out = 1'b0;
		cs_n_out = 1'b1;
		si_out = 1'b0;
	end

	// ==========================================
	// Frame sender
	// Fewer than 32 bits leaves a partial frame; link period is 8 clocks
	task automatic send(input logic [31:0] frame, input int n);
		@(posedge clk_in);
		cs_n_out <= 1'b0;
		// Select settles in the decoder before the first edge
		repeat (2) @(posedge clk_in);
		for (int i = 0; i < n; i++) begin
			si_out <= frame[31-i];
			repeat (2) @(posedge clk_in);
			sck_out <= 1'b1;
			repeat (4) @(posedge clk_in);
			sck_out <= 1'b0;
			repeat (2) @(posedge clk_in);
		end
		repeat (6) @(posedge clk_in);
		cs_n_out <= 1'b1;
		// Released line must not keep the last bit
		si_out <= ~si_out;
		repeat (10) @(posedge clk_in);
	endtask
endmodule

// ===== testbench.sv
// Self-checking bench for the flash address-space decoder.
// Assumes the host model drives the link; lock bits come from here.
`timescale 1ns/100ps

module testbench;
	localparam int SECTORS = 512;
	// Arbitrary identifier value
	localparam logic [63:0] UID = 64'h5a3c_0f96_c3a5_7e18;
	logic clk_in;
	logic rst_n_in;
	logic sck;
	logic cs_n;
	logic si;
	logic [3:0] lock_bits;
	logic decode_valid;
	flash_space_pkg::decode_type decode;
	flash_space_pkg::decode_type seen_q[$];
	int miscompares;
	int checks;
	flash_space_pkg::decode_type last_dec;
	logic [7:0] ptrs[3] = '{8'h0c, 8'h14, 8'h1c};
	logic [23:0] array_addrs[5] = '{24'h000000, 24'h000fff, 24'h1ff000, 24'h1fffff, 24'h200000};
	logic [7:0] sec_cmds[3] = '{8'h48, 8'h42, 8'h44};

	spi_host_model i_spi_host_model (.clk_in(clk_in), .sck_out(sck), .cs_n_out(cs_n),
		.si_out(si));

	flash_space_map #(.SECTORS(SECTORS), .UNIQUE_ID(UID)) i_flash_space_map (
		.clk_in(clk_in), .rst_n_in(rst_n_in), .sck_in(sck), .cs_n_in(cs_n), .si_in(si),
		.lock_bits_in(lock_bits), .decode_valid_out(decode_valid), .decode_out(decode));

	initial begin
		clk_in = 1'b0;
		forever #25 clk_in = ~clk_in;
	end

	// Sampled mid-cycle, where the one-cycle pulse has settled
	always @(negedge clk_in) begin
		if (decode_valid === 1'b1) begin
			seen_q.push_back(decode);
		end
	end

	// ==========================================
	// Checking
	task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic stop_test();
		if (miscompares == 0 && checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// Bit 8 marks a byte whose value is pinned down
	function automatic logic [8:0] rom(input logic [7:0] a);
		case (a)
			8'h00: rom = 9'h153;
			8'h01: rom = 9'h146;
			8'h02: rom = 9'h144;
			8'h03: rom = 9'h150;
			8'h0c: rom = 9'h180;
			8'h14: rom = 9'h190;
			8'h1c: rom = 9'h1b0;
			default: begin
				if (a >= 8'hf8) begin
					rom = {1'b1, UID[8*(a-8'hf8) +: 8]};
				end else begin
					rom = ((a >= 8'h20 && a < 8'h80) || a >= 8'hc0) ? 9'h1ff : 9'h000;
				end
			end
		endcase
	endfunction

	// ==========================================
	// One frame plus its expected decode
	task automatic run(input logic [7:0] cmd, input logic [23:0] a, input logic [3:0] lk,
			input int n);
		flash_space_pkg::decode_type d;
		int sp;
		logic def;
		logic wr;
		logic [1:0] rg;
		logic [8:0] rb;
		@(posedge clk_in);
		lock_bits <= lk;
		seen_q.delete();
		i_spi_host_model.send({cmd, a}, n);
		cmp("frames", n == 32, seen_q.size());
		if (seen_q.size() != 1) return;
		d = seen_q.pop_front();
		last_dec = d;
		rb = rom(a[7:0]);
		sp = cmd == 8'h03 ? 1 : cmd == 8'h5a ? 3 : cmd inside {8'h48, 8'h42, 8'h44} ? 2 : 0;
		rg = a[13:12];
		wr = cmd inside {8'h42, 8'h44};
		def = sp == 1 ? a < SECTORS * 4096 : sp == 2 ? a[23:14] == 0 && a[11:8] == 0 : a[23:8] == 0;
		cmp("space", sp, d.space);
		cmp("addr", a, d.addr);
		if (sp == 0) return;
		cmp("defined", def, d.defined);
		cmp("write", wr, d.write_req);
		cmp("reject", wr && (rg == 0 || lk[rg] || !def), d.reject);
		if (sp == 1 && def) cmp("sector", a[22:12], d.sector);
		if (sp == 2) cmp("region", rg, d.region);
		if (sp > 1) cmp("offset", a[7:0], d.offset);
		if (sp == 3 && def && rb[8]) cmp("rom", rb, {1'b1, d.rom_byte});
		if (sp == 2 && rg == 2'h0 && def && rb[8]) cmp("alias", rb, {1'b1, d.rom_byte});
	endtask

	initial begin
		#2000000;
		miscompares++;
		stop_test();
	end

	// Reset held for 5 clocks, then the outputs must read idle and cleared
	task automatic pulse_reset();
		rst_n_in <= 1'b0;
		repeat (5) @(posedge clk_in);
		rst_n_in <= 1'b1;
		repeat (6) @(posedge clk_in);
		cmp("idle", 0, {decode_valid, decode.addr});
	endtask

	// ==========================================
	// Scenarios
	initial begin
		miscompares = 0;
		checks = 0;
		lock_bits = 4'h0;
		void'($urandom(32'hdaa0));
		pulse_reset();
		for (int i = 0; i < 4; i++) run(8'h5a, 24'(i), 4'h0, 32);
		foreach (ptrs[i]) begin
			run(8'h5a, {16'h0000, ptrs[i]}, 4'h0, 32);
			run(8'h5a, {16'h0000, last_dec.rom_byte}, 4'h0, 32);
		end
		for (int i = 0; i < 8; i++) run(8'h5a, 24'(8'hf8 + i), 4'h0, 32);
		for (int i = 0; i < 6; i++) run(8'h5a, 24'($urandom % 256), 4'($urandom), 32);
		run(8'h5a, 24'h000100, 4'h0, 32);
		run(8'h44, 24'h000010, 4'h0, 32);
		run(8'h42, 24'h000020, 4'h0, 32);
		foreach (array_addrs[i]) run(8'h03, array_addrs[i], 4'h0, 32);
		for (int i = 0; i < 4; i++) run(8'h03, 24'($urandom % 32'h0020_0000), 4'h0, 32);
		foreach (sec_cmds[c]) begin
			for (int r = 0; r < 4; r++) begin
				run(sec_cmds[c], {10'h000, r[1:0], 4'h0, 8'($urandom)}, 4'($urandom), 32);
			end
		end
		run(8'h42, 24'h001010, 4'h0, 32);
		run(8'h42, 24'h001010, 4'h2, 32);
		run(8'h44, 24'h002000, 4'h2, 32);
		run(8'h44, 24'h001100, 4'h0, 32);
		run(8'h48, 24'h004000, 4'h0, 32);
		run(8'h00, 24'($urandom), 4'h0, 32);
		run(8'h5a, 24'h0, 4'h0, 16);
		pulse_reset();
		run(8'h5a, 24'h0, 4'h0, 32);
		stop_test();
	end
endmodule
